// ### include/dsc_map.svh
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
// =====================================================================
// Register offsets (byte addresses on APB).
`define DSC_OFS_CTRL      12'h000
`define DSC_OFS_ADDR      12'h004
`define DSC_OFS_STATUS    12'h008
`define DSC_OFS_MASK      12'h00C
`define DSC_OFS_COUNT     12'h010
// =====================================================================
// Control register field positions.
`define DSC_BIT_ENABLE    7
`define DSC_BIT_SIZE      6
`define DSC_BIT_DIR       5
`define DSC_BIT_REPEAT    4
`define DSC_BIT_IRQEN     3
`define DSC_SEL_HI        2
`define DSC_SEL_LO        0
// =====================================================================
// Reset values.
`define DSC_CTRL_RST      8'h00
`define DSC_ADDR_RST      24'h00_0000
`define DSC_COUNT_RST     16'h0000
`endif

// ### include/dsc_pkg.sv
// =====================================================================
// Types of the short address mode channel.
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_MODE_IO,
    DSC_MODE_REPEAT,
    DSC_MODE_IDLE
  } dsc_mode_e;
  typedef enum logic {
    DSC_ST_WAIT,
    DSC_ST_MOVE
  } dsc_state_e;
endpackage : dsc_pkg

// ### core/dsc_channel.sv
// What this block does
// - With enable clear, no transfers happen and source requests are ignored.
// - With enable set, a selected request seen in the wait state starts one transfer; irq gated.
// - Address counter steps up or down, by one for bytes, two for words.
// - Select field picks timer 0-3, serial empty/full, pin edge or low level.
`include "dsc_map.svh"
`default_nettype none
module dsc_channel
  import dsc_pkg::*;
(
  // Clock, reset, enable.
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Activation sources.
  input  wire logic [3:0]  timer_match_in,
  input  wire logic        serial_tx_empty_in,
  input  wire logic        serial_rx_full_in,
  input  wire logic        ext_req_n_in,
  // Transfer side.
  output logic             xfer_start_out,
  output logic             xfer_word_out,
  output logic      [23:0] xfer_addr_out,
  output logic      [1:0]  mode_out,
  output logic             irq_out
);

  // ===================================================================
  // Decode used by both the read path and the write path.
  function automatic logic [2:0] dsc_decode(input logic [11:0] a);
    unique case (a)
      `DSC_OFS_CTRL:   dsc_decode = 3'h1;
      `DSC_OFS_ADDR:   dsc_decode = 3'h2;
      `DSC_OFS_STATUS: dsc_decode = 3'h3;
      `DSC_OFS_MASK:   dsc_decode = 3'h4;
      `DSC_OFS_COUNT:  dsc_decode = 3'h5;
      default:         dsc_decode = 3'h0;
    endcase
  endfunction : dsc_decode

  // ===================================================================
  // State.
  logic [7:0]  ctrl_q,   ctrl_d;
  logic [23:0] addr_q,   addr_d;
  logic [15:0] count_q,  count_d;
  logic        sts_q,    sts_d;
  logic        mask_q,   mask_d;
  logic        pin_q,    pin_d;
  dsc_state_e  st_q,     st_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        perr_q,   perr_d;
  logic        start_q,  start_d;
  logic        irq_q,    irq_d;
  logic [1:0]  mode_q,   mode_d;

  // Combinational request, completion and bus decode seen by both processes.
  logic        req;
  logic        done;
  logic        access;
  logic [2:0]  sel;
  dsc_mode_e   mode;

  // An access is captured once: the raised pready blocks a second capture.
  assign access = psel_in & penable_in & ~pready_q;
  assign sel    = dsc_decode(paddr_in);

  // ===================================================================
  // Mode and source selection.
  always_comb begin
    // Defaults keep the process free of latches.
    mode = DSC_MODE_IO;
    req  = 1'b0;
    if (ctrl_q[`DSC_BIT_REPEAT]) begin
      mode = ctrl_q[`DSC_BIT_IRQEN] ? DSC_MODE_IDLE : DSC_MODE_REPEAT;
    end
    // Codes 0 to 3 index the timer lines directly.
    unique case (ctrl_q[`DSC_SEL_HI:`DSC_SEL_LO])
      3'h0, 3'h1, 3'h2, 3'h3: req = timer_match_in[ctrl_q[1:0]];
      3'h4:    req = serial_tx_empty_in;
      3'h5:    req = serial_rx_full_in;
      3'h6:    req = pin_q & ~ext_req_n_in; // Falling edge of the pin.
      3'h7:    req = ~ext_req_n_in;         // Low level on the pin.
    endcase
  end

  // ===================================================================
  // Next-state logic for registers, channel and bus answer.
  always_comb begin
    ctrl_d   = ctrl_q;
    addr_d   = addr_q;
    count_d  = count_q;
    mask_d   = mask_q;
    st_d     = st_q;
    start_d  = 1'b0;
    done     = 1'b0;
    pin_d    = ext_req_n_in;
    prdata_d = prdata_q;
    pready_d = access;
    perr_d   = access & (sel == 3'h0);
    // One cycle per transfer; a held level request repeats every two cycles.
    unique case (st_q)
      DSC_ST_WAIT: begin
        if (ctrl_q[`DSC_BIT_ENABLE] && req) begin
          st_d    = DSC_ST_MOVE;
          start_d = 1'b1;
        end
      end
      DSC_ST_MOVE: begin
        st_d = DSC_ST_WAIT;
        done = 1'b1;
        // The transfer count wraps silently at its width.
        count_d = 16'(count_q + 16'h0001);
        if (ctrl_q[`DSC_BIT_DIR]) begin
          addr_d = 24'(addr_q - (ctrl_q[`DSC_BIT_SIZE] ? 24'h00_0002 : 24'h00_0001));
        end else begin
          addr_d = 24'(addr_q + (ctrl_q[`DSC_BIT_SIZE] ? 24'h00_0002 : 24'h00_0001));
        end
      end
    endcase
    // Completion event only counts toward the interrupt when irq is enabled.
    sts_d = sts_q | (done & ctrl_q[`DSC_BIT_IRQEN]);
    if (access) begin
      unique case (sel)
        3'h1: prdata_d = {24'h00_0000, ctrl_q};
        3'h2: prdata_d = {8'h00, addr_q};
        3'h3: prdata_d = {31'h0000_0000, sts_q};
        3'h4: prdata_d = {31'h0000_0000, mask_q};
        3'h5: prdata_d = {16'h0000, count_q};
        default: prdata_d = 32'h0000_0000;
      endcase
      if (pwrite_in) begin
        unique case (sel)
          3'h1: ctrl_d = pwdata_in[7:0];
          3'h2: addr_d = pwdata_in[23:0];
          // Set wins over a write-one clear landing in the same cycle.
          3'h3: sts_d  = (sts_q & ~pwdata_in[0]) | (done & ctrl_q[`DSC_BIT_IRQEN]);
          3'h4: mask_d = pwdata_in[0];
          3'h5: count_d = pwdata_in[15:0];
          default: ;
        endcase
      end
    end
    mode_d = mode;
    irq_d  = sts_d & mask_d;
  end

  // ===================================================================
  // Registers, frozen while the clock enable is low.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_q   <= `DSC_CTRL_RST;
      addr_q   <= `DSC_ADDR_RST;
      count_q  <= `DSC_COUNT_RST;
      sts_q    <= 1'b0;
      mask_q   <= 1'b0;
      // The pin sample starts at its idle high level, so no false edge follows reset.
      pin_q    <= 1'b1;
      st_q     <= DSC_ST_WAIT;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
      start_q  <= 1'b0;
      irq_q    <= 1'b0;
      mode_q   <= 2'h0;
    end else if (clk_en_in) begin
      ctrl_q   <= ctrl_d;
      addr_q   <= addr_d;
      count_q  <= count_d;
      sts_q    <= sts_d;
      mask_q   <= mask_d;
      pin_q    <= pin_d;
      st_q     <= st_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      perr_q   <= perr_d;
      start_q  <= start_d;
      irq_q    <= irq_d;
      mode_q   <= mode_d;
    end
  end

  // Every output is a flop; the size bit is read straight from the control flop.
  assign prdata_out     = prdata_q;
  assign pready_out     = pready_q;
  assign pslverr_out    = perr_q;
  assign xfer_start_out = start_q;
  assign xfer_word_out  = ctrl_q[`DSC_BIT_SIZE];
  assign xfer_addr_out  = addr_q;
  assign mode_out       = mode_q;
  assign irq_out        = irq_q;

  // ===================================================================
  // Checks.
  default clocking dsc_cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  property p_no_start_disabled;
    clk_en_in && !ctrl_q[`DSC_BIT_ENABLE] |=> !start_q;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled)
    else $error("transfer started while disabled");

  property p_start_on_req;
    clk_en_in && ctrl_q[`DSC_BIT_ENABLE] && req && st_q == DSC_ST_WAIT |=> start_q;
  endproperty
  a_start_on_req: assert property (p_start_on_req)
    else $error("request not served");

  property p_step;
    clk_en_in && st_q == DSC_ST_MOVE && !(access && pwrite_in && sel == 3'h2) |=>
      addr_q == 24'($past(addr_q) + ($past(ctrl_q[`DSC_BIT_DIR]) ?
        -($past(ctrl_q[`DSC_BIT_SIZE]) ? 24'h00_0002 : 24'h00_0001) :
        ($past(ctrl_q[`DSC_BIT_SIZE]) ? 24'h00_0002 : 24'h00_0001)));
  endproperty
  a_step: assert property (p_step)
    else $error("address step wrong");

  property p_tx_sel;
    ctrl_q[2:0] == 3'h4 |-> req == serial_tx_empty_in;
  endproperty
  a_tx_sel: assert property (p_tx_sel)
    else $error("source select wrong");

  property p_mode;
    clk_en_in |=> mode_q == (!$past(ctrl_q[`DSC_BIT_REPEAT]) ? 2'(DSC_MODE_IO) :
      $past(ctrl_q[`DSC_BIT_IRQEN]) ? 2'(DSC_MODE_IDLE) : 2'(DSC_MODE_REPEAT));
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode output wrong");

  property p_irq_gate;
    clk_en_in && done && !ctrl_q[`DSC_BIT_IRQEN] && !sts_q |=> !sts_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("status set with irq disabled");

  property p_timer_sel;
    !ctrl_q[`DSC_SEL_HI] |-> req == timer_match_in[ctrl_q[1:0]];
  endproperty
  a_timer_sel: assert property (p_timer_sel)
    else $error("timer source select wrong");

  property p_edge_sel;
    $past(clk_en_in) && !$past(reset_in) && ctrl_q[`DSC_SEL_HI:`DSC_SEL_LO] == 3'h6 |->
      req == ($past(ext_req_n_in) && !ext_req_n_in);
  endproperty
  a_edge_sel: assert property (p_edge_sel)
    else $error("pin edge select wrong");

  property p_level_sel;
    ctrl_q[`DSC_SEL_HI:`DSC_SEL_LO] == 3'h7 |-> req == !ext_req_n_in;
  endproperty
  a_level_sel: assert property (p_level_sel)
    else $error("pin level select wrong");

  property p_irq_level;
    irq_q == (sts_q && mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not follow status and mask");

  property p_sts_set;
    clk_en_in && done && ctrl_q[`DSC_BIT_IRQEN] |=> sts_q;
  endproperty
  a_sts_set: assert property (p_sts_set)
    else $error("completion did not set status");

  property p_one_pulse;
    clk_en_in && start_q |=> !start_q;
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("transfer pulse longer than one cycle");

  property p_idle_disabled;
    clk_en_in && !ctrl_q[`DSC_BIT_ENABLE] && st_q == DSC_ST_WAIT |=> st_q == DSC_ST_WAIT;
  endproperty
  a_idle_disabled: assert property (p_idle_disabled)
    else $error("disabled channel left idle");

  property p_addr_held;
    clk_en_in && !ctrl_q[`DSC_BIT_ENABLE] && st_q == DSC_ST_WAIT &&
      !(access && pwrite_in && sel == 3'h2) |=> $stable(addr_q);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("address moved while disabled");

  // Main scenarios: a transfer, a word transfer, an interrupt, idle mode, a step down.
  c_start:  cover property (start_q);
  c_word:   cover property (start_q && xfer_word_out);
  c_irq:    cover property (irq_q);
  c_idle:   cover property (mode_q == 2'(DSC_MODE_IDLE));
  c_down:   cover property (start_q && ctrl_q[`DSC_BIT_DIR]);

endmodule : dsc_channel
`default_nettype wire

// ### testbench/dsc_src_model.sv
`default_nettype none
// =====================================================================
// Activation sources facing the channel.
module dsc_src_model (
  // Command from the bench.
  input  wire logic [2:0] req_code_in,
  input  wire logic       req_on_in,
  // Source lines.
  output logic      [3:0] timer_match_out,
  output logic            serial_tx_empty_out,
  output logic            serial_rx_full_out,
  output logic            ext_req_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only the commanded source requests; the pin idles high as with a pull-up.
  assign timer_match_out     = (req_on_in && !req_code_in[2]) ?
                               4'h1 << req_code_in[1:0] : 4'h0;
  assign serial_tx_empty_out = req_on_in && (req_code_in == 3'h4);
  assign serial_rx_full_out  = req_on_in && (req_code_in == 3'h5);
  assign ext_req_n_out       = !(req_on_in && (req_code_in[2:1] == 2'h3));
endmodule : dsc_src_model
`default_nettype wire

// ### testbench/dsc_channel_tb.sv
`include "dsc_map.svh"
`default_nettype none
// =====================================================================
// Bench for the short address mode channel.
module dsc_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, on = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, prd, q;
  logic        rdy, serr, err, tx, rx, external_request_pin_n, st, wd, irq;
  logic [3:0]  tm;
  logic [2:0]  code = 3'h0;
  logic [23:0] xa;
  logic [1:0]  mode;
  logic        ce = 1'b1;
  logic [31:0] ea;
  int          n_errors = 0, n_checks = 0, n_starts = 0;
  always #5 clk = ~clk;
  // Count transfer pulses so a request can be judged by how many it caused.
  always @(posedge clk) if (st === 1'b1) n_starts++;
  dsc_src_model u_src (.req_code_in(code), .req_on_in(on), .timer_match_out(tm),
    .serial_tx_empty_out(tx), .serial_rx_full_out(rx), .ext_req_n_out(external_request_pin_n));
  dsc_channel u_dut (.core_clk_in(clk), .reset_in(rst), .clk_en_in(ce), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(serr), .timer_match_in(tm), .serial_tx_empty_in(tx),
    .serial_rx_full_in(rx), .ext_req_n_in(external_request_pin_n), .xfer_start_out(st), .xfer_word_out(wd),
    .xfer_addr_out(xa), .mode_out(mode), .irq_out(irq));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; pready, read data and error are all taken at one rising edge.
  // Only the watchdog ends a wait for pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q    = prd;
    err  = serr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  // Raise one request and count the transfers that follow.
  task automatic fire(input logic [2:0] c, input int exp, input string nm);
    int s0;
    s0 = n_starts;
    @(posedge clk);
    code <= c;
    on   <= 1'b1;
    @(posedge clk);
    on <= 1'b0;
    repeat (5) @(posedge clk);
    chk(nm, exp, 32'(n_starts - s0));
  endtask : fire
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // The whole run needs well under this many cycles.
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `DSC_OFS_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0000_0000, q);
    chk("mapped_err", 32'h0000_0000, {31'h0, err});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h0000_0001, {31'h0, err});
    chk("unmapped_rd", 32'h0000_0000, q);
    fire(3'h0, 0, "disabled");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `DSC_OFS_CTRL, 32'h80 | c);
      fire(3'(c), 1, "source");
      fire(3'(c) ^ 3'h4, 0, "other_source");
    end
    for (int i = 0; i < 4; i++) begin
      ea = i[1] ? (i[0] ? 32'h0000_0FFE : 32'h0000_1002) :
        (i[0] ? 32'h0000_0FFF : 32'h0000_1001);
      apb(1'b1, `DSC_OFS_ADDR, 32'h0000_1000);
      apb(1'b1, `DSC_OFS_CTRL, 32'h84 | (i << 5));
      fire(3'h4, 1, "step_xfer");
      apb(1'b0, `DSC_OFS_ADDR, 32'h0);
      chk("addr", ea, q);
      chk("addr_out", ea, {8'h00, xa});
      chk("word_out", {31'h0, i[1]}, {31'h0, wd});
    end
    apb(1'b1, `DSC_OFS_MASK, 32'h1);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `DSC_OFS_CTRL, 32'h85 | (m << 3));
      apb(1'b1, `DSC_OFS_STATUS, 32'h1);
      chk("mode", m[1] ? (m[0] ? 32'h2 : 32'h1) : 32'h0, {30'h0, mode});
      fire(3'h5, 1, "irq_xfer");
      chk("irq", {31'h0, m[0]}, {31'h0, irq});
    end
    apb(1'b0, `DSC_OFS_STATUS, 32'h0);
    chk("status", 32'h0000_0001, q);
    // A request while the clock enable is low must cause nothing.
    @(posedge clk);
    ce <= 1'b0;
    fire(3'h5, 0, "frozen");
    ce <= 1'b1;
    apb(1'b0, `DSC_OFS_COUNT, 32'h0);
    chk("count", 32'h0000_0010, q);
    apb(1'b1, `DSC_OFS_MASK, 32'h0);
    @(negedge clk) chk("irq_masked", 32'h0, {31'h0, irq});
    test_done();
  end
endmodule : dsc_channel_tb
`default_nettype wire
